// >>> xfer_cmd_pkg.sv
package xfer_cmd_pkg;
    localparam int NUM_UNITS = 8;
    localparam int MAX_DEPTH = 9;
    localparam int NUM_STAT_WORDS = 5;
    // Bus map
    localparam logic [7:0] OFS_STATUS_WORD = 8'h04;
    localparam logic [7:0] ADDR_SHADOW_ALLOC = 8'h40;
    localparam logic [7:0] ADDR_TIMEOUT_ROUTE = 8'h44;
    localparam logic [7:0] ADDR_COMPL_STAT0 = 8'h48;
    // Field positions
    localparam int DOORBELL_LSB = 16;
    localparam int HOP_LSB = 8;
    localparam int FTYPE_LSB = 4;
    localparam int BUSY_BIT = 31;
    localparam int FULL_BIT = 30;
    localparam int PRIV_LSB = 28;
    localparam int RELEASE_BIT = 27;
    localparam int SEL_LSB = 2;
    localparam int RESTART_BIT = 1;
    localparam int FLUSH_BIT = 0;
    localparam int GRP_HIGH_LSB = 16;
    localparam int TIMEOUT_LSB = 8;
    // Reset values
    localparam logic [31:0] TYPE_WORD_RESET = 32'h0000ff00;
    localparam logic [3:0] DEPTH_RESET = 4'h4;
    localparam logic CTX_RESET = 1'b1;
    localparam logic [3:0] TRANSACTION_SLOT_INDEX_RESET = 4'h0;
    // Request kinds
    localparam logic [3:0] FT_READ = 4'h2;
    localparam logic [3:0] FT_WRITE = 4'h5;
    localparam logic [3:0] FT_STREAM = 4'h6;
    localparam logic [3:0] FT_MAINT = 4'h8;
    localparam logic [3:0] FT_DOORBELL = 4'ha;
    // Completion codes
    localparam logic [2:0] CC_OK = 3'h0;
    localparam logic [2:0] CC_TIMEOUT = 3'h1;
    localparam logic [2:0] CC_BLOCKED = 3'h2;
    localparam logic [2:0] CC_ERR_RESP = 3'h3;
    localparam logic [2:0] CC_BAD_TYPE = 3'h4;
    localparam logic [2:0] CC_XFER_ERR = 3'h5;
    localparam logic [2:0] CC_RETRY = 3'h6;
    localparam logic [2:0] CC_KILLED = 3'h7;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SEND = 2'b01,
        ST_WAIT = 2'b11,
        ST_FROZEN = 2'b10
    } engine_state_t;
    typedef struct packed {
        logic [15:0] info;
        logic [7:0] hop;
        logic [3:0] ftype;
        logic [3:0] ttype;
        logic [3:0] src;
        logic [3:0] transaction_slot_index;
        logic ctx;
    } shadow_entry_t;
endpackage : xfer_cmd_pkg

// >>> transfer_unit_command_status.sv
`timescale 1ns/1ps
// Operation
// [RULE1] Format type selects read/write/stream/maintenance/doorbell
// [RULE2] Undefined format type: no packet, code 100
// [RULE3] Hop count used by maintenance only
// [RULE4] Upper sixteen bits become doorbell info
// [RULE5] Subtype used only for types 2,5,8
// [RULE6] Bit 31 reads busy state
// [RULE7] Bit 30 reads all shadows occupied
// [RULE8] Context bit readable, resets to one
// [RULE9] Slot index of submitted transaction readable
// [RULE10] Force release needs matching owner id
// [RULE11] Restart resumes frozen transaction
// [RULE12] Flush discards matching shadows, beats restart
// [RULE13] Allocation read shows depths, reset four
// [RULE14] Allocation changed only while logic disabled
// [RULE15] Five-bit group codes at 4-0, 20-16
// [RULE16] Discard after N+1 time code changes
// [RULE17] Routing bit picks good-completion interrupt target
// [RULE18] Codes 000 to 011 meanings
// [RULE19] Codes 100 to 111 meanings
// [RULE20] Slot holds code bits 3-1, context bit 0
// [RULE21] Slots packed unit after unit
// [RULE22] Software reads slot and context after submit
module transfer_unit_command_status (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // System context
    input wire logic [3:0] bus_priv_id,
    input wire logic lsu_enable,
    input wire logic [31:0] unit_src_map,
    input wire logic timecode_tick,
    // Packet engine request
    output logic pkt_req_valid,
    input wire logic pkt_ready,
    output logic [2:0] pkt_unit,
    output logic [3:0] pkt_ftype,
    output logic [3:0] pkt_ttype,
    output logic [7:0] pkt_hop,
    output logic [15:0] pkt_info,
    output logic [3:0] pkt_src,
    // Packet engine completion
    input wire logic cpl_valid,
    input wire logic [2:0] cpl_code,
    // Good-completion pulses
    output logic [7:0] good_unit_irq,
    output logic [15:0] good_src_irq
);
    import xfer_cmd_pkg::*;

    logic [31:0] type_word_reg [NUM_UNITS];
    shadow_entry_t shadow_mem [NUM_UNITS][MAX_DEPTH];
    logic [3:0] slot_reg [NUM_UNITS][MAX_DEPTH];
    logic [3:0] wr_ptr_reg [NUM_UNITS];
    logic [3:0] rd_ptr_reg [NUM_UNITS];
    logic [3:0] count_reg [NUM_UNITS];
    logic [3:0] transaction_slot_index_reg [NUM_UNITS];
    logic [3:0] shown_transaction_slot_index_reg [NUM_UNITS];
    logic [3:0] depth_reg [NUM_UNITS];
    logic [3:0] owner_reg [NUM_UNITS];
    logic [3:0] flush_sel_reg [NUM_UNITS];
    logic [NUM_UNITS-1:0] ctx_reg, kill_reg, flush_reg, shown_ctx_reg;
    logic [1:0] timeout_reg;
    logic [7:0] route_reg;
    engine_state_t state_reg;
    logic [2:0] eng_unit_reg, held_code_reg, tick_cnt_reg;

    logic [31:0] lane_mask, wdata_m, rd_data;
    logic bus_write, in_unit_space, alloc_wr;
    logic [NUM_UNITS-1:0] sub_hit, sub_bad, sub_ok, stat_wr, full, held;
    logic [NUM_UNITS-1:0] head_match, pop, release_ok;
    logic [31:0] type_next [NUM_UNITS];
    logic [2:0] pop_code [NUM_UNITS];
    shadow_entry_t head [NUM_UNITS];
    logic [4*MAX_DEPTH*NUM_UNITS-1:0] stat_vec;
    logic pick_valid, flush_now, restart_now, timeout_done, eng_pop;
    logic [2:0] pick_unit, eng_pop_code;

    function automatic logic ftype_defined(input logic [3:0] ft);
        return ft == FT_READ || ft == FT_WRITE || ft == FT_STREAM ||
               ft == FT_MAINT || ft == FT_DOORBELL; // [RULE1]
    endfunction : ftype_defined

    function automatic logic [3:0] wrap_inc(input logic [3:0] v, input logic [3:0] d);
        return (v + 4'h1 >= d) ? 4'h0 : 4'(v + 4'h1);
    endfunction : wrap_inc

    // Group code to depth; codes outside the table load the reset depth of four
    function automatic logic [3:0] grp_depth(input logic [4:0] c, input int idx);
        logic [3:0] d;
        d = DEPTH_RESET;
        if (c >= 5'h01 && c <= 5'h05)
            d = 4'(c);
        else if (c == 5'h06)
            d = (idx == 0) ? 4'h9 : (idx == 3) ? 4'h1 : 4'h5;
        return d;
    endfunction : grp_depth

    // Bus decode; byte lanes gate every written field
    always_comb
    begin
        for (int b = 0; b < 4; b++)
            lane_mask[8*b +: 8] = {8{wb_sel_i[b]}};
    end
    assign wdata_m = wb_dat_i & lane_mask;
    assign bus_write = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o; // Lands at the acked edge
    assign in_unit_space = wb_adr_i < ADDR_SHADOW_ALLOC;
    assign alloc_wr = bus_write & (wb_adr_i[7:2] == ADDR_SHADOW_ALLOC[7:2]) & ~lsu_enable; // [RULE14]

    // Per-unit submission, drain and head decode
    always_comb
    begin
        for (int u = 0; u < NUM_UNITS; u++)
        begin
            sub_hit[u] = bus_write & in_unit_space & (wb_adr_i[5:3] == 3'(u)) & ~wb_adr_i[2];
            stat_wr[u] = bus_write & in_unit_space & (wb_adr_i[5:3] == 3'(u)) & wb_adr_i[2];
            type_next[u] = (type_word_reg[u] & ~lane_mask) | wdata_m;
            full[u] = count_reg[u] == depth_reg[u]; // [RULE7]
            sub_bad[u] = sub_hit[u] & ~full[u] & ~ftype_defined(type_next[u][FTYPE_LSB +: 4]); // [RULE2]
            sub_ok[u] = sub_hit[u] & ~full[u] & ftype_defined(type_next[u][FTYPE_LSB +: 4]);
            head[u] = shadow_mem[u][rd_ptr_reg[u]];
            head_match[u] = head[u].src == flush_sel_reg[u];
            held[u] = (state_reg != ST_IDLE) && (eng_unit_reg == 3'(u));
            release_ok[u] = stat_wr[u] & wdata_m[RELEASE_BIT] &
                            (wdata_m[PRIV_LSB +: 4] == owner_reg[u]); // [RULE10]
            pop[u] = (eng_pop && held[u]) || (count_reg[u] != 4'h0 && !held[u] &&
                     (kill_reg[u] || (flush_reg[u] && head_match[u])));
            pop_code[u] = held[u] ? eng_pop_code : kill_reg[u] ? CC_KILLED : held_code_reg; // [RULE19]
        end
    end

    // Engine decisions: flush over restart over timeout
    always_comb
    begin
        pick_valid = 1'b0;
        pick_unit = 3'h0;
        for (int u = NUM_UNITS - 1; u >= 0; u--)
        begin
            if (count_reg[u] != 4'h0 && !kill_reg[u] && !flush_reg[u] && lsu_enable)
            begin
                pick_valid = 1'b1;
                pick_unit = 3'(u);
            end
        end
        flush_now = state_reg == ST_FROZEN && stat_wr[eng_unit_reg] && wdata_m[FLUSH_BIT]; // [RULE12]
        restart_now = state_reg == ST_FROZEN && stat_wr[eng_unit_reg] &&
                      wdata_m[RESTART_BIT] && !flush_now; // [RULE11]
        timeout_done = state_reg == ST_FROZEN && timecode_tick && !flush_now && !restart_now &&
                       tick_cnt_reg == {1'b0, timeout_reg}; // [RULE16]
        eng_pop = (state_reg == ST_WAIT && cpl_valid && cpl_code != CC_TIMEOUT &&
                   cpl_code != CC_ERR_RESP && cpl_code != CC_XFER_ERR) ||
                  (flush_now && head[eng_unit_reg].src == wdata_m[SEL_LSB +: 4]) ||
                  timeout_done; // Held head meets the selector being written
        eng_pop_code = (state_reg == ST_WAIT) ? cpl_code : held_code_reg; // [RULE18]
    end

    // Status slots packed unit after unit by current depth
    always_comb
    begin
        int base;
        base = 0;
        stat_vec = '0;
        for (int u = 0; u < NUM_UNITS; u++)
        begin
            for (int s = 0; s < MAX_DEPTH; s++)
            begin
                if (s < int'(depth_reg[u]) && base < NUM_STAT_WORDS * 8)
                begin
                    stat_vec[4*base +: 4] = slot_reg[u][s]; // [RULE21]
                    base = base + 1;
                end
            end
        end
    end

    // Read mux
    always_comb
    begin
        logic [7:0] rel;
        rel = wb_adr_i - ADDR_COMPL_STAT0;
        rd_data = '0;
        if (in_unit_space && !wb_adr_i[2])
            rd_data = type_word_reg[wb_adr_i[5:3]];
        else if (in_unit_space)
        begin
            rd_data[BUSY_BIT] = count_reg[wb_adr_i[5:3]] != 4'h0; // [RULE6]
            rd_data[FULL_BIT] = full[wb_adr_i[5:3]]; // [RULE7]
            rd_data[4] = shown_ctx_reg[wb_adr_i[5:3]]; // [RULE8]
            rd_data[3:0] = shown_transaction_slot_index_reg[wb_adr_i[5:3]]; // [RULE9]
        end
        else if (wb_adr_i[7:2] == ADDR_SHADOW_ALLOC[7:2])
        begin
            for (int u = 0; u < NUM_UNITS; u++)
                rd_data[4*u +: 4] = depth_reg[u]; // [RULE13]
        end
        else if (wb_adr_i[7:2] == ADDR_TIMEOUT_ROUTE[7:2])
            rd_data[TIMEOUT_LSB + 1:0] = {timeout_reg, route_reg};
        else if (wb_adr_i >= ADDR_COMPL_STAT0 && rel[7:2] < 6'(NUM_STAT_WORDS))
            rd_data = stat_vec[32*rel[4:2] +: 32];
    end

    // Bus answer one cycle after the strobe, any address
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end
        else
        begin
            wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
            wb_dat_o <= rd_data;
        end
    end

    // Setup registers; reserved bits never stored
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            timeout_reg <= 2'h0;
            route_reg <= 8'h00;
        end
        else if (bus_write && wb_adr_i[7:2] == ADDR_TIMEOUT_ROUTE[7:2])
        begin
            if (wb_sel_i[1])
                timeout_reg <= wb_dat_i[TIMEOUT_LSB +: 2];
            if (wb_sel_i[0])
                route_reg <= wb_dat_i[7:0];
        end
    end

    // Shadow storage holds queued descriptors; no reset needed
    always_ff @(posedge clk_sys)
    begin
        for (int u = 0; u < NUM_UNITS; u++)
        begin
            if (sub_ok[u])
                shadow_mem[u][wr_ptr_reg[u]] <= '{
                    info: type_next[u][DOORBELL_LSB +: 16],
                    hop: type_next[u][HOP_LSB +: 8],
                    ftype: type_next[u][FTYPE_LSB +: 4],
                    ttype: type_next[u][3:0],
                    src: unit_src_map[4*u +: 4],
                    transaction_slot_index: transaction_slot_index_reg[u],
                    ctx: ctx_reg[u]};
        end
    end

    // Queue, slot index, context and allocation per unit
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            for (int u = 0; u < NUM_UNITS; u++)
            begin
                type_word_reg[u] <= TYPE_WORD_RESET; // [RULE3]
                wr_ptr_reg[u] <= 4'h0;
                rd_ptr_reg[u] <= 4'h0;
                count_reg[u] <= 4'h0;
                transaction_slot_index_reg[u] <= TRANSACTION_SLOT_INDEX_RESET;
                depth_reg[u] <= DEPTH_RESET;
                owner_reg[u] <= 4'h0;
                flush_sel_reg[u] <= 4'h0;
                ctx_reg[u] <= CTX_RESET;
                shown_ctx_reg[u] <= CTX_RESET;
                shown_transaction_slot_index_reg[u] <= TRANSACTION_SLOT_INDEX_RESET;
                kill_reg[u] <= 1'b0;
                flush_reg[u] <= 1'b0;
            end
        end
        else
        begin
            for (int u = 0; u < NUM_UNITS; u++)
            begin
                if (sub_hit[u])
                    type_word_reg[u] <= type_next[u];
                if (sub_ok[u])
                begin
                    wr_ptr_reg[u] <= wrap_inc(wr_ptr_reg[u], depth_reg[u]);
                    owner_reg[u] <= bus_priv_id;
                end
                if (pop[u])
                    rd_ptr_reg[u] <= wrap_inc(rd_ptr_reg[u], depth_reg[u]);
                count_reg[u] <= count_reg[u] + 4'(sub_ok[u]) - 4'(pop[u]);
                if (sub_ok[u] || sub_bad[u])
                begin
                    shown_transaction_slot_index_reg[u] <= transaction_slot_index_reg[u]; // Slot of the submission just taken
                    shown_ctx_reg[u] <= ctx_reg[u];
                    transaction_slot_index_reg[u] <= wrap_inc(transaction_slot_index_reg[u], depth_reg[u]); // [RULE9]
                    if (wrap_inc(transaction_slot_index_reg[u], depth_reg[u]) == 4'h0)
                        ctx_reg[u] <= ~ctx_reg[u]; // [RULE8]
                end
                if (release_ok[u])
                    kill_reg[u] <= 1'b1; // [RULE10]
                else if (count_reg[u] == 4'h0)
                    kill_reg[u] <= 1'b0;
                if (flush_now && held[u])
                begin
                    flush_reg[u] <= 1'b1;
                    flush_sel_reg[u] <= wdata_m[SEL_LSB +: 4]; // [RULE12]
                end
                else if (stat_wr[u] && state_reg != ST_FROZEN)
                    flush_sel_reg[u] <= wdata_m[SEL_LSB +: 4];
                else if (count_reg[u] == 4'h0 || (!head_match[u] && !held[u]))
                    flush_reg[u] <= 1'b0;
                if (alloc_wr && wb_sel_i[(u < 4) ? 0 : 2])
                begin
                    depth_reg[u] <= grp_depth(wdata_m[(u < 4) ? 0 : GRP_HIGH_LSB +: 5], u % 4); // [RULE15]
                    wr_ptr_reg[u] <= 4'h0;
                    rd_ptr_reg[u] <= 4'h0;
                    count_reg[u] <= 4'h0;
                    transaction_slot_index_reg[u] <= TRANSACTION_SLOT_INDEX_RESET;
                    shown_transaction_slot_index_reg[u] <= TRANSACTION_SLOT_INDEX_RESET;
                end
            end
        end
    end

    // Completion slots: code above, context bit below
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            for (int u = 0; u < NUM_UNITS; u++)
                for (int s = 0; s < MAX_DEPTH; s++)
                    slot_reg[u][s] <= 4'h0;
        end
        else
        begin
            for (int u = 0; u < NUM_UNITS; u++)
            begin
                if (sub_bad[u])
                    slot_reg[u][transaction_slot_index_reg[u]] <= {CC_BAD_TYPE, ctx_reg[u]}; // [RULE2]
                if (pop[u])
                    slot_reg[u][head[u].transaction_slot_index] <= {pop_code[u], head[u].ctx}; // [RULE20]
            end
        end
    end

    // Single packet engine: dispatch, wait, freeze on error
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_reg <= ST_IDLE;
            eng_unit_reg <= 3'h0;
            held_code_reg <= CC_OK;
            tick_cnt_reg <= 3'h0;
            pkt_req_valid <= 1'b0;
            pkt_unit <= 3'h0;
            pkt_ftype <= 4'h0;
            pkt_ttype <= 4'h0;
            pkt_hop <= 8'h00;
            pkt_info <= 16'h0000;
            pkt_src <= 4'h0;
        end
        else
        begin
            unique case (state_reg)
                ST_IDLE:
                begin
                    if (pick_valid)
                    begin
                        state_reg <= ST_SEND;
                        eng_unit_reg <= pick_unit;
                        pkt_req_valid <= 1'b1;
                        pkt_unit <= pick_unit;
                        pkt_ftype <= head[pick_unit].ftype; // [RULE1]
                        pkt_src <= head[pick_unit].src;
                        pkt_ttype <= (head[pick_unit].ftype == FT_READ ||
                                      head[pick_unit].ftype == FT_WRITE ||
                                      head[pick_unit].ftype == FT_MAINT) ?
                                     head[pick_unit].ttype : 4'h0; // [RULE5]
                        pkt_hop <= (head[pick_unit].ftype == FT_MAINT) ?
                                   head[pick_unit].hop : 8'h00; // [RULE3]
                        pkt_info <= (head[pick_unit].ftype == FT_DOORBELL) ?
                                    head[pick_unit].info : 16'h0000; // [RULE4]
                    end
                end
                ST_SEND:
                begin
                    if (pkt_ready)
                    begin
                        pkt_req_valid <= 1'b0;
                        state_reg <= ST_WAIT;
                    end
                end
                ST_WAIT:
                begin
                    if (cpl_valid)
                    begin
                        held_code_reg <= cpl_code;
                        tick_cnt_reg <= 3'h0;
                        state_reg <= eng_pop ? ST_IDLE : ST_FROZEN;
                    end
                end
                ST_FROZEN:
                begin
                    if (flush_now || timeout_done)
                        state_reg <= ST_IDLE;
                    else if (restart_now)
                    begin
                        state_reg <= ST_SEND; // [RULE11]
                        pkt_req_valid <= 1'b1;
                    end
                    else if (timecode_tick)
                        tick_cnt_reg <= tick_cnt_reg + 3'h1; // [RULE16]
                end
            endcase
        end
    end

    // Good-completion pulses routed per unit
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            good_unit_irq <= 8'h00;
            good_src_irq <= 16'h0000;
        end
        else
        begin
            good_unit_irq <= 8'h00;
            good_src_irq <= 16'h0000;
            if (eng_pop && state_reg == ST_WAIT && cpl_code == CC_OK)
            begin
                if (route_reg[eng_unit_reg])
                    good_unit_irq[eng_unit_reg] <= 1'b1; // [RULE17]
                else
                    good_src_irq[pkt_src] <= 1'b1; // [RULE17]
            end
        end
    end

    a_bad_type_code: assert property (@(posedge clk_sys) disable iff (!arst_n)
        sub_bad[0] |=> slot_reg[0][$past(transaction_slot_index_reg[0])][3:1] == CC_BAD_TYPE) // [RULE2]
        else $error("bad type not coded 100");
    a_hop_maint_only: assert property (@(posedge clk_sys) disable iff (!arst_n)
        pkt_req_valid && pkt_ftype != FT_MAINT |-> pkt_hop == 8'h00) // [RULE3]
        else $error("hop count leaked");
    a_info_doorbell: assert property (@(posedge clk_sys) disable iff (!arst_n)
        pkt_req_valid && pkt_ftype != FT_DOORBELL |-> pkt_info == 16'h0000) // [RULE4]
        else $error("doorbell info leaked");
    a_full_no_push: assert property (@(posedge clk_sys) disable iff (!arst_n)
        full[0] && !pop[0] && !alloc_wr |=> count_reg[0] == $past(count_reg[0])) // [RULE7]
        else $error("push while full");
    a_flush_beats_restart: assert property (@(posedge clk_sys) disable iff (!arst_n)
        flush_now && wdata_m[RESTART_BIT] |=> state_reg == ST_IDLE) // [RULE12]
        else $error("restart beat flush");
    a_timeout_discard: assert property (@(posedge clk_sys) disable iff (!arst_n)
        timeout_done |=> state_reg == ST_IDLE ##1 !held[$past(eng_unit_reg, 2)] || pick_valid) // [RULE16]
        else $error("timeout not discarded");
    a_restart_resend: assert property (@(posedge clk_sys) disable iff (!arst_n)
        restart_now |=> pkt_req_valid && pkt_unit == $past(eng_unit_reg)) // [RULE11]
        else $error("restart lost");
    a_good_irq_route: assert property (@(posedge clk_sys) disable iff (!arst_n)
        eng_pop && state_reg == ST_WAIT && cpl_code == CC_OK && route_reg[eng_unit_reg]
        |=> $onehot(good_unit_irq) && good_src_irq == 16'h0000) // [RULE17]
        else $error("good irq misrouted");
endmodule : transfer_unit_command_status

// >>> pkt_engine_model.sv
`timescale 1ns/1ps
// Far-side packet engine: slow accept, then one completion
module pkt_engine_model (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // Request and completion
    input wire logic pkt_req_valid,
    output logic pkt_ready,
    output logic cpl_valid,
    output logic [2:0] cpl_code,
    // Code picked by the bench
    input wire logic [2:0] code_sel
);
    logic [3:0] cnt_reg;
    // Ready three cycles after valid, completion three later
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cnt_reg <= 4'h0;
        end
        else if (pkt_req_valid || cnt_reg != 4'h0)
        begin
            cnt_reg <= (cnt_reg == 4'h6) ? 4'h0 : cnt_reg + 4'h1;
        end
    end
    assign pkt_ready = (cnt_reg == 4'h3);
    assign cpl_valid = (cnt_reg == 4'h6);
    // Code inverted outside the pulse, so a stale value never passes
    assign cpl_code = cpl_valid ? code_sel : ~code_sel;
endmodule : pkt_engine_model

// >>> transfer_unit_command_status_tb_top.sv
`timescale 1ns/1ps
module transfer_unit_command_status_tb_top;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, en = 1'b1;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0, dat_o, q;
    logic ack, vld, rdy, cv, tick = 1'b0;
    logic [3:0] priv = 4'h3, tt;
    logic [2:0] cc, unit, code = 3'h0;
    logic [3:0] ft, src;
    logic [7:0] hop, girq;
    logic [15:0] info, sirq;
    int num_errors = 0, n_compared = 0;
    // Clock at 20 MHz
    always #25 clk_sys = ~clk_sys;
    transfer_unit_command_status i_transfer_unit_command_status (.clk_sys(clk_sys),
        .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .bus_priv_id(priv), .lsu_enable(en), .unit_src_map(32'h76543210),
        .timecode_tick(tick), .pkt_req_valid(vld), .pkt_ready(rdy), .pkt_unit(unit),
        .pkt_ftype(ft), .pkt_ttype(tt), .pkt_hop(hop), .pkt_info(info), .pkt_src(src),
        .cpl_valid(cv), .cpl_code(cc), .good_unit_irq(girq), .good_src_irq(sirq));
    pkt_engine_model i_pkt_engine_model (.clk_sys(clk_sys), .arst_n(arst_n),
        .pkt_req_valid(vld), .pkt_ready(rdy), .cpl_valid(cv), .cpl_code(cc),
        .code_sel(code));
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : wrap_up
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e)
        begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // One classic cycle; holds the request until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
        do begin @(posedge clk_sys); n++; end while (ack !== 1'b1 && n < 20);
        q = dat_o;
        cyc <= 1'b0; stb <= 1'b0;
        if (n >= 20)
        begin
            $display("BAD ack expected 1 seen 0");
            num_errors++;
            wrap_up();
        end
    endtask : wb
    // Poll the status word until busy drops
    task automatic wait_idle(input logic [7:0] a);
        int n;
        n = 0;
        do begin wb(1'b0, a, 32'h0); n++; end while (q[31] !== 1'b0 && n < 40);
        if (n >= 40)
        begin
            $display("BAD busy expected 0 seen 1");
            num_errors++;
            wrap_up();
        end
    endtask : wait_idle
    task automatic t_reset;
        wb(1'b0, 8'h00, 32'h0); chk("type0", 32'h0000ff00, q);
        wb(1'b0, 8'h04, 32'h0); chk("stat0", 32'h00000010, q);
        wb(1'b0, 8'h40, 32'h0); chk("alloc", 32'h44444444, q);
        wb(1'b0, 8'h44, 32'h0); chk("route", 32'h0, q);
        $display("test reset done");
    endtask : t_reset
    task automatic t_doorbell;
        int n;
        n = 0;
        wb(1'b1, 8'h00, 32'h123477a5);
        while (vld !== 1'b1 && n < 20) begin @(posedge clk_sys); n++; end
        chk("ftype", 32'ha, ft);
        chk("info", 32'h1234, info);
        chk("ttype", 32'h0, tt);
        chk("hop", 32'h0, hop);
        wait_idle(8'h04); chk("next", 32'h00000010, q);
        $display("test doorbell done");
    endtask : t_doorbell
    task automatic t_bad_type;
        wb(1'b1, 8'h00, 32'h0000ff30);
        repeat (3) @(posedge clk_sys);
        chk("nopkt", 32'h0, vld);
        $display("test bad type done");
    endtask : t_bad_type
    // Unit 2 freezes on errors: restart, then timeout, then flush over restart
    task automatic t_freeze;
        int n;
        n = 0;
        code <= 3'h1;
        wb(1'b1, 8'h44, 32'h00000104);
        wb(1'b1, 8'h10, 32'h1234ff83);
        while (vld !== 1'b1 && n < 20)
        begin
            @(posedge clk_sys);
            n++;
        end
        chk("hop", 32'hff, hop);
        chk("ttype", 32'h3, tt);
        chk("info", 32'h0, info);
        chk("unit_src", 32'h22, {unit, src});
        repeat (8) @(posedge clk_sys);
        code <= 3'h0;
        wb(1'b1, 8'h14, 32'h00000002);
        n = 0;
        while (girq === 8'h00 && n < 40)
        begin
            @(posedge clk_sys);
            n++;
        end
        chk("irq", 32'h00040000, {girq, sirq});
        code <= 3'h1;
        wb(1'b1, 8'h10, 32'h0000ff80);
        repeat (12) @(posedge clk_sys);
        tick <= 1'b1;
        repeat (2) @(posedge clk_sys);
        tick <= 1'b0;
        wb(1'b1, 8'h10, 32'h0000ff80);
        repeat (12) @(posedge clk_sys);
        wb(1'b1, 8'h14, 32'h0000000b);
        wait_idle(8'h14); chk("stat2", 32'h00000012, q);
        wb(1'b0, 8'h4c, 32'h0); chk("slots2", 32'h00000331, q);
        $display("test freeze done");
    endtask : t_freeze
    task automatic t_release;
        en <= 1'b0;
        repeat (4) wb(1'b1, 8'h08, 32'h00000050);
        wb(1'b0, 8'h0c, 32'h0); chk("full", 32'hc0000013, q);
        wb(1'b1, 8'h0c, 32'h58000000);
        wb(1'b0, 8'h0c, 32'h0); chk("keep", 32'h1, q[31]);
        wb(1'b1, 8'h0c, 32'h38000000);
        wait_idle(8'h0c);
        wb(1'b0, 8'h48, 32'h0); chk("slots", 32'hffff0091, q);
        $display("test release done");
    endtask : t_release
    task automatic t_alloc;
        wb(1'b1, 8'h40, 32'hffe5ffe1);
        wb(1'b0, 8'h40, 32'h0); chk("alloc", 32'h55551111, q);
        wb(1'b0, 8'h60, 32'h0); chk("unmap", 32'h0, q);
        $display("test alloc done");
    endtask : t_alloc
    initial
    begin
        repeat (16) @(posedge clk_sys);
        arst_n <= 1'b1;
        t_reset();
        t_doorbell();
        t_bad_type();
        t_freeze();
        t_release();
        t_alloc();
        wrap_up();
    end
endmodule : transfer_unit_command_status_tb_top
